// file: core/multimode_timer.sv
// multimode_timer: two 16-bit down-counting timers with rate, square,
// one-shot and single-pulse modes, count latch and byte-wide host port.
// assumes: host pins are asynchronous and held stable for several
// system clocks around each strobe; timer clock comes from tick_divider.
//
// Functional notes
// R1 - mode 1 runs continuously, low when stopped
// R2 - start mode 1: load preset, output active
// R3 - mode 1 zero: one tick inactive, reload
// R4 - mode 1 period is preset plus one
// R5 - modes 1, 2 suspended by gate
// R6 - mode 1 interrupt on every zero
// R7 - mode 2 start: load, output high
// R8 - mode 2 toggles at zero, then reloads
// R9 - mode 2 interrupt on output falling edge
// R10 - mode 3 output idle until trigger
// R11 - mode 3 trigger: output active, load next
// R12 - mode 3 retrigger reloads, output unchanged
// R13 - mode 3 pulse width is preset ticks
// R14 - mode 3 interrupt only at zero
// R15 - host clears stale gate via mode 0
// R16 - data reads give preset when read clear
// R17 - read bit latches count into bytes
// R18 - low-byte read clears read bit
// R19 - read latch aligned to decrement clock
// R20 - two-bit mode field selects mode
// R21 - gate pin ORed with hold bit
// R22 - suspended gate holds count and output
// R23 - mode 3 zero: output inactive, rearm
`default_nettype none

module multimode_timer #(
	parameter int unsigned TICK_DIV = timer_pkg::TICK_DIV
) (
	input  wire logic       SYS_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       CS_N_I,
	input  wire logic       RD_N_I,
	input  wire logic       WR_N_I,
	input  wire logic [4:0] ADDR_I,
	input  wire logic [7:0] DATA_I,
	output logic      [7:0] DATA_O,
	output logic            DATA_OE_O,
	input  wire logic       GATE_PIN_ZERO_I,
	input  wire logic       GATE_PIN_ONE_I,
	output logic            MULTI_FUNCTION_OUTPUT_PIN_O,
	output logic            SECOND_TIMER_OUTPUT_PIN_O,
	output logic            INTERRUPT_REQUEST_PIN_O
);

	localparam int unsigned NCH = timer_pkg::NUM_CH;
	localparam int unsigned SW  = 3 + timer_pkg::ADDR_W + timer_pkg::DATA_W + NCH;

	typedef struct packed {
		timer_pkg::chan_state_t st;
		logic [15:0]            cnt;
		logic [15:0]            latch;
		logic [7:0]             ctrl;
		logic [7:0]             pre_lo;
		logic [7:0]             pre_hi;
		logic                   out;
		logic                   gate_prev;
		logic                   irq;
	} chan_t;

	typedef struct packed {
		chan_t [NCH-1:0] ch;
		logic            rd_prev;
		logic            wr_prev;
		logic [7:0]      dout;
		logic            doe;
		logic            multi_function_output_pin;
		logic            t1;
		logic            interrupt_request_pin;
	} top_t;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and timer clock

	logic [SW-1:0] pins_raw;
	logic [SW-1:0] pins_s;
	logic          cs_s;
	logic          rd_s;
	logic          wr_s;
	logic [4:0]    addr_s;
	logic [7:0]    din_s;
	logic [1:0]    gate_s;
	logic          tick;

	tick_if tk ();

	assign pins_raw = {CS_N_I, RD_N_I, WR_N_I, ADDR_I, DATA_I,
		GATE_PIN_ONE_I, GATE_PIN_ZERO_I};

	// strobes reset high so release of reset is not seen as an access
	pin_sync #(
		.W    (SW),
		.INIT ({3'h7, {(SW - 3){1'b0}}})
	) u_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     (pins_raw),
		.q_o     (pins_s)
	);

	assign {cs_s, rd_s, wr_s, addr_s, din_s, gate_s} = pins_s;

	tick_divider #(
		.DIV (TICK_DIV)
	) u_div (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.tick_o  (tk.source)
	);

	assign tick = tk.tick;

	////////////////////////////////////////////////////////////////////
	// one channel, one system clock

	function automatic chan_t chan_step(
		input chan_t      c,
		input logic       tk_i,
		input logic       gate_pin,
		input logic       wr_ctrl,
		input logic       wr_lo,
		input logic       wr_hi,
		input logic [7:0] wdata,
		input logic       rd_lo_latched,
		input logic       irq_clr
	);
		chan_t       n;
		logic        gate;
		logic        trig;
		logic        zero;
		logic        oneshot;
		logic [1:0]  mode;
		logic [15:0] preset;
		n = c;
		// R21 gate OR hold
		gate    = gate_pin | c.ctrl[timer_pkg::HOLD_BIT];
		trig    = gate & ~c.gate_prev;
		n.gate_prev = gate;
		// R20 mode decode
		mode    = c.ctrl[timer_pkg::MODE_HI:timer_pkg::MODE_LO];
		oneshot = (mode == timer_pkg::MODE_ONESHOT);
		preset  = {c.pre_hi, c.pre_lo};
		zero    = (c.cnt <= timer_pkg::CNT_ONE);

		// cleared first, so a zero event later in this step wins
		if (irq_clr) begin
			n.irq = 1'b0;
		end
		if (wr_lo) begin
			n.pre_lo = wdata;
		end
		if (wr_hi) begin
			n.pre_hi = wdata;
		end
		if (wr_ctrl) begin
			n.ctrl = wdata;
			// R17 R19 latch count
			// the count register only changes on a clock edge, so the
			// latched pair is always one coherent value
			if (wdata[timer_pkg::READ_BIT]) begin
				n.latch = c.cnt;
			end
		end
		// R18 auto clear read
		if (rd_lo_latched) begin
			n.ctrl[timer_pkg::READ_BIT] = 1'b0;
		end

		if (!c.ctrl[timer_pkg::RUN_BIT]) begin
			// R1 R7 low when stopped
			n.st  = timer_pkg::ST_STOP;
			n.out = 1'b0;
		end else begin
			case (c.st)
				timer_pkg::ST_STOP: begin
					// R10 arm only, output idle
					if (oneshot) begin
						n.st = timer_pkg::ST_ARMED;
					end else begin
						n.st = timer_pkg::ST_LOAD;
					end
				end
				timer_pkg::ST_LOAD: begin
					// R2 R7 R11 load on tick
					if (tk_i) begin
						n.cnt = preset;
						n.st  = timer_pkg::ST_COUNT;
						n.out = 1'b1;
					end
				end
				timer_pkg::ST_COUNT: begin
					if (oneshot && trig) begin
						// R12 retrigger reload
						n.st = timer_pkg::ST_LOAD;
					end else if (tk_i && (oneshot || !gate)) begin
						// R5 R22 gate suspends
						if (zero) begin
							n.cnt = '0;
							case (mode)
								timer_pkg::MODE_RATE: begin
									// R3 R4 R6 one tick low
									n.out = 1'b0;
									n.irq = 1'b1;
									n.st  = timer_pkg::ST_RELOAD;
								end
								timer_pkg::MODE_SQUARE: begin
									// R8 R9 toggle at zero
									n.out = ~c.out;
									if (c.out) begin
										n.irq = 1'b1;
									end
									n.st = timer_pkg::ST_RELOAD;
								end
								timer_pkg::MODE_ONESHOT: begin
									// R13 R14 R23 end of pulse
									n.out = 1'b0;
									n.irq = 1'b1;
									n.st  = timer_pkg::ST_ARMED;
								end
								default: begin
									// single pulse stops itself
									n.out = 1'b0;
									n.irq = 1'b1;
									n.ctrl[timer_pkg::RUN_BIT] = 1'b0;
									n.st  = timer_pkg::ST_STOP;
								end
							endcase
						end else begin
							n.cnt = c.cnt - timer_pkg::CNT_ONE;
						end
					end
				end
				timer_pkg::ST_RELOAD: begin
					// R3 R5 reload next tick
					if (tk_i && !gate) begin
						n.cnt = preset;
						n.st  = timer_pkg::ST_COUNT;
						if (mode == timer_pkg::MODE_RATE) begin
							n.out = 1'b1;
						end
					end
				end
				timer_pkg::ST_ARMED: begin
					// R11 output active at once
					if (trig) begin
						n.out = 1'b1;
						n.st  = timer_pkg::ST_LOAD;
					end
				end
				default: begin
					n.st = timer_pkg::ST_STOP;
				end
			endcase
		end
		// a host write to the run bit takes effect over the step above
		if (wr_ctrl) begin
			n.ctrl[timer_pkg::RUN_BIT] = wdata[timer_pkg::RUN_BIT];
		end
		return n;
	endfunction : chan_step

	////////////////////////////////////////////////////////////////////
	// host bus decode and next state

	top_t r_r;
	top_t r_nxt;

	logic       rd_start;
	logic       rd_end;
	logic       wr_start;
	logic [7:0] rdata;

	assign rd_start = !cs_s && !rd_s && r_r.rd_prev;
	assign rd_end   = rd_s && !r_r.rd_prev;
	assign wr_start = !cs_s && !wr_s && r_r.wr_prev;

	function automatic logic [7:0] data_byte(input chan_t c, input logic hi);
		logic [15:0] v;
		// R16 R17 preset or latch
		if (c.ctrl[timer_pkg::READ_BIT]) begin
			v = c.latch;
		end else begin
			v = {c.pre_hi, c.pre_lo};
		end
		return hi ? v[15:8] : v[7:0];
	endfunction : data_byte

	always_comb begin
		case (addr_s)
			timer_pkg::ADDR_STATUS: rdata = {6'h00, r_r.ch[1].irq, r_r.ch[0].irq};
			timer_pkg::ADDR_CTRL0:  rdata = r_r.ch[0].ctrl;
			timer_pkg::ADDR_CTRL1:  rdata = r_r.ch[1].ctrl;
			timer_pkg::ADDR_T0_LO:  rdata = data_byte(r_r.ch[0], 1'b0);
			timer_pkg::ADDR_T0_HI:  rdata = data_byte(r_r.ch[0], 1'b1);
			timer_pkg::ADDR_T1_LO:  rdata = data_byte(r_r.ch[1], 1'b0);
			timer_pkg::ADDR_T1_HI:  rdata = data_byte(r_r.ch[1], 1'b1);
			default:                rdata = 8'h00;
		endcase
	end

	always_comb begin
		logic [4:0] a_ctrl;
		logic [4:0] a_lo;
		logic [4:0] a_hi;
		r_nxt         = r_r;
		a_ctrl        = timer_pkg::ADDR_CTRL0;
		a_lo          = timer_pkg::ADDR_T0_LO;
		a_hi          = timer_pkg::ADDR_T0_HI;
		r_nxt.rd_prev = cs_s | rd_s;
		r_nxt.wr_prev = cs_s | wr_s;
		for (int i = 0; i < NCH; i++) begin
			a_ctrl = (i == 0) ? timer_pkg::ADDR_CTRL0 : timer_pkg::ADDR_CTRL1;
			a_lo   = (i == 0) ? timer_pkg::ADDR_T0_LO : timer_pkg::ADDR_T1_LO;
			a_hi   = (i == 0) ? timer_pkg::ADDR_T0_HI : timer_pkg::ADDR_T1_HI;
			r_nxt.ch[i] = chan_step(r_r.ch[i], tick, gate_s[i],
				wr_start && (addr_s == a_ctrl),
				wr_start && (addr_s == a_lo),
				wr_start && (addr_s == a_hi),
				din_s,
				rd_start && (addr_s == a_lo) && r_r.ch[i].ctrl[timer_pkg::READ_BIT],
				wr_start && (addr_s == timer_pkg::ADDR_STATUS) && din_s[i]);
		end
		// read data is captured at the strobe edge so the auto clear
		// of the read bit cannot change the byte the host is sampling
		if (rd_start) begin
			r_nxt.dout = rdata;
			r_nxt.doe  = 1'b1;
		end else if (rd_end || cs_s) begin
			r_nxt.doe = 1'b0;
		end
		r_nxt.multi_function_output_pin  = r_nxt.ch[0].out ^ r_nxt.ch[0].ctrl[timer_pkg::POL_BIT];
		r_nxt.t1   = r_nxt.ch[1].out ^ r_nxt.ch[1].ctrl[timer_pkg::POL_BIT];
		r_nxt.interrupt_request_pin = r_nxt.ch[0].irq | r_nxt.ch[1].irq;
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			r_r         <= '0;
			r_r.rd_prev <= 1'b1;
			r_r.wr_prev <= 1'b1;
			for (int i = 0; i < NCH; i++) begin
				r_r.ch[i].st     <= timer_pkg::ST_STOP;
				r_r.ch[i].ctrl   <= timer_pkg::CTRL_RST;
				r_r.ch[i].pre_lo <= timer_pkg::PRESET_RST;
				r_r.ch[i].pre_hi <= timer_pkg::PRESET_RST;
			end
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all registered

	assign DATA_O                      = r_r.dout;
	assign DATA_OE_O                   = r_r.doe;
	assign MULTI_FUNCTION_OUTPUT_PIN_O = r_r.multi_function_output_pin;
	assign SECOND_TIMER_OUTPUT_PIN_O   = r_r.t1;
	assign INTERRUPT_REQUEST_PIN_O     = r_r.interrupt_request_pin;

endmodule : multimode_timer

`default_nettype wire

// file: core/pin_sync.sv
// pin_sync: two-flop synchroniser for a group of pin inputs.
// assumes: the bits are independent levels; no bus coherency is given.
`default_nettype none

module pin_sync #(
	parameter int unsigned   W    = 1,
	parameter logic [W-1:0]  INIT = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t r_r;
	sync_t r_nxt;

	always_comb begin
		r_nxt    = r_r;
		r_nxt.s1 = d_i;
		r_nxt.s2 = r_r.s1;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_r <= '{s1: INIT, s2: INIT};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign q_o = r_r.s2;

endmodule : pin_sync

`default_nettype wire

// file: core/tick_divider.sv
// tick_divider: one-cycle enable every DIV system clocks; each pulse
// stands for one falling edge of the timer clock.
// assumes: DIV >= 1.
`default_nettype none

module tick_divider #(
	parameter int unsigned DIV = timer_pkg::TICK_DIV
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	tick_if.source    tick_o
);

	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} div_t;

	div_t r_r;
	div_t r_nxt;

	always_comb begin
		r_nxt      = r_r;
		r_nxt.tick = 1'b0;
		if (r_r.cnt == LAST) begin
			r_nxt.cnt  = '0;
			r_nxt.tick = 1'b1;
		end else begin
			r_nxt.cnt = r_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign tick_o.tick = r_r.tick;

endmodule : tick_divider

`default_nettype wire

// file: pkg/tick_if.sv
// tick_if: carries the timer-clock enable from the divider to the timers.
// assumes: source and sink share the system clock.
`default_nettype none

interface tick_if;
	logic tick;
	modport source (output tick);
	modport sink   (input  tick);
endinterface : tick_if

`default_nettype wire

// file: pkg/timer_pkg.sv
// timer_pkg: register map, control fields, modes and timing constants
// of the two-channel multimode timer.
// assumes: one 25 MHz system clock; the timer clock is a tick enable.
`default_nettype none

package timer_pkg;

	////////////////////////////////////////////////////////////////////
	// clocking
	localparam int unsigned SYS_CLK_HZ   = 25_000_000;
	localparam int unsigned TIMER_CLK_HZ = 1_000_000;
	localparam int unsigned TICK_DIV     = SYS_CLK_HZ / TIMER_CLK_HZ;

	////////////////////////////////////////////////////////////////////
	// byte-wide host bus
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned NUM_CH = 2;

	localparam logic [4:0] ADDR_STATUS  = 5'h00;
	localparam logic [4:0] ADDR_CTRL0   = 5'h01;
	localparam logic [4:0] ADDR_CTRL1   = 5'h02;
	localparam logic [4:0] ADDR_T0_LO   = 5'h0F;
	localparam logic [4:0] ADDR_T0_HI   = 5'h10;
	localparam logic [4:0] ADDR_T1_LO   = 5'h11;
	localparam logic [4:0] ADDR_T1_HI   = 5'h12;

	////////////////////////////////////////////////////////////////////
	// timer control register fields
	localparam int unsigned RUN_BIT    = 0;
	localparam int unsigned MODE_LO    = 1;
	localparam int unsigned MODE_HI    = 2;
	localparam int unsigned HOLD_BIT   = 3;
	localparam int unsigned READ_BIT   = 4;
	localparam int unsigned POL_BIT    = 5;

	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  PRESET_RST = 8'h00;
	localparam logic [15:0] CNT_ONE    = 16'h0001;

	localparam logic [1:0] MODE_SINGLE  = 2'h0;
	localparam logic [1:0] MODE_RATE    = 2'h1;
	localparam logic [1:0] MODE_SQUARE  = 2'h2;
	localparam logic [1:0] MODE_ONESHOT = 2'h3;

	typedef enum logic [2:0] {
		ST_STOP,
		ST_LOAD,
		ST_COUNT,
		ST_RELOAD,
		ST_ARMED
	} chan_state_t;

endpackage : timer_pkg

`default_nettype wire

// file: tb/multimode_timer_monitor.sv
// multimode_timer_monitor: port-level assertions for the timer block.
// assumes: bound to multimode_timer; the bench triggers timer1 only in one-shot mode.
`default_nettype none

module multimode_timer_monitor #(
	parameter int unsigned TICK_DIV = 25
) (
	input wire logic       SYS_CLK_I,
	input wire logic       RST_N_I,
	input wire logic       CS_N_I,
	input wire logic       RD_N_I,
	input wire logic       WR_N_I,
	input wire logic [7:0] DATA_O,
	input wire logic       DATA_OE_O,
	input wire logic       GATE_PIN_ZERO_I,
	input wire logic       GATE_PIN_ONE_I,
	input wire logic       MULTI_FUNCTION_OUTPUT_PIN_O,
	input wire logic       SECOND_TIMER_OUTPUT_PIN_O,
	input wire logic       INTERRUPT_REQUEST_PIN_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);

	// recent output edges; the flag and the pins may land a clock apart
	logic [2:0] edge_r;
	always_ff @(posedge SYS_CLK_I) begin
		edge_r <= {edge_r[1:0], $changed(MULTI_FUNCTION_OUTPUT_PIN_O) ||
			$changed(SECOND_TIMER_OUTPUT_PIN_O)};
	end

	sequence gate0_held;
		GATE_PIN_ZERO_I [*6];
	endsequence
	sequence write_held;
		(!CS_N_I && !WR_N_I && RD_N_I) [*4];
	endsequence

	////////////////////////////////////////////////////////////////////
	read_answer_a: assert property ($rose(DATA_OE_O) |->
		$past(RD_N_I, 2) == 1'b0 && $past(CS_N_I, 2) == 1'b0)
		else $error("data driven without a read strobe");
	oe_release_a: assert property ($rose(RD_N_I) |-> ##[1:4] !DATA_OE_O)
		else $error("data bus not released after read");
	write_quiet_a: assert property (write_held |-> !DATA_OE_O)
		else $error("data bus driven during write");
	data_stable_a: assert property (DATA_OE_O && $past(DATA_OE_O) |-> $stable(DATA_O))
		else $error("read data changed while driven");
	irq_clear_cause_a: assert property ($fell(INTERRUPT_REQUEST_PIN_O) |->
		$past(WR_N_I, 3) == 1'b0 || $past(WR_N_I, 4) == 1'b0)
		else $error("interrupt dropped without a write");
	irq_with_edge_a: assert property ($rose(INTERRUPT_REQUEST_PIN_O) |->
		$changed(MULTI_FUNCTION_OUTPUT_PIN_O) || $changed(SECOND_TIMER_OUTPUT_PIN_O) ||
		(|edge_r))
		else $error("interrupt without an output edge");
	gate_freeze_a: assert property (gate0_held |=> $stable(MULTI_FUNCTION_OUTPUT_PIN_O))
		else $error("output moved while gated");
	trigger_rise_a: assert property ($rose(GATE_PIN_ONE_I) |->
		##[1:6] SECOND_TIMER_OUTPUT_PIN_O)
		else $error("one-shot output missed its trigger");
endmodule : multimode_timer_monitor

bind multimode_timer multimode_timer_monitor #(.TICK_DIV(TICK_DIV)) mon_u (
	.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .RD_N_I(RD_N_I),
	.WR_N_I(WR_N_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
	.GATE_PIN_ZERO_I(GATE_PIN_ZERO_I), .GATE_PIN_ONE_I(GATE_PIN_ONE_I),
	.MULTI_FUNCTION_OUTPUT_PIN_O(MULTI_FUNCTION_OUTPUT_PIN_O),
	.SECOND_TIMER_OUTPUT_PIN_O(SECOND_TIMER_OUTPUT_PIN_O),
	.INTERRUPT_REQUEST_PIN_O(INTERRUPT_REQUEST_PIN_O));

`default_nettype wire

// file: tb/multimode_timer_tb.sv
// multimode_timer_tb: self-checking tests of the timer through its pins.
// assumes: design, package, monitor and host model compiled before it.
`default_nettype none

module multimode_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DIV = 4;
	logic       clk, rst_n, g0, g1, cs_n, rd_n, wr_n, oe, multi_function_output_pin, t1o, irq;
	logic       tog = 1'b0;
	logic [4:0] addr;
	logic [7:0] din, dout, bus, v;
	logic [7:0] regs [32];
	int         n_errors, n_checks, seed, n, n0, n1;

	// undriven bus toggles so a stale value never reads as data
	assign bus = oe ? dout : {8{tog}};

	multimode_timer #(.TICK_DIV(DIV)) dut_u (.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n), .ADDR_I(addr), .DATA_I(din),
		.DATA_O(dout), .DATA_OE_O(oe), .GATE_PIN_ZERO_I(g0), .GATE_PIN_ONE_I(g1),
		.MULTI_FUNCTION_OUTPUT_PIN_O(multi_function_output_pin), .SECOND_TIMER_OUTPUT_PIN_O(t1o),
		.INTERRUPT_REQUEST_PIN_O(irq));
	timer_host_model host_u (.clk_i(clk), .bus_i(bus), .oe_i(oe), .cs_n_o(cs_n),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(din));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) tog <= ~tog;

	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
		n_checks++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("Error at %0t: %s took %0d not %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_cnt
	task automatic mw(input logic [4:0] a, input logic [7:0] d);
		host_u.wr(a, d);
		if (a >= 5'h0F && a <= 5'h12) regs[a] = d;
	endtask : mw
	task automatic mr(input logic [4:0] a, output logic [7:0] d);
		logic ok;
		host_u.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01, "read answer");
	endtask : mr
	task automatic span(input bit ch, input logic lvl, output int k);
		k = 0;
		while ((ch ? t1o : multi_function_output_pin) === lvl && k < 4000) begin
			@(negedge clk);
			k++;
		end
	endtask : span
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	initial begin
		#(40 * 40000);
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 89;
		rst_n = 1'b0;
		g0 = 1'b0;
		g1 = 1'b0;
		foreach (regs[i]) regs[i] = 8'h00;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		for (int a = 15; a <= 19; a++) mw(a[4:0], 8'($random(seed)));
		for (int a = 15; a <= 19; a++) begin
			mr(a[4:0], v);
			chk(v, regs[a], "register read");
		end
		$display("test registers done");
		n0 = 20 + ($unsigned($random(seed)) % 21);
		mw(5'h10, 8'h00);
		mw(5'h0F, 8'(n0));
		mw(5'h01, 8'h02);
		chk({7'h00, multi_function_output_pin}, 8'h00, "stopped low");
		mw(5'h01, 8'h22);
		chk({7'h00, multi_function_output_pin}, 8'h01, "inverted stopped");
		mw(5'h01, 8'h03);
		// first high phase starts inside the write and is not measured
		span(0, 1'b0, n);
		span(0, 1'b1, n);
		span(0, 1'b0, n1);
		chk_cnt(n1, DIV, DIV, "rate low");
		span(0, 1'b1, n);
		chk_cnt(n, n0 * DIV, n0 * DIV, "rate high");
		chk_cnt(n + n1, (n0 + 1) * DIV, (n0 + 1) * DIV, "rate period");
		repeat (2) @(negedge clk);
		chk({7'h00, irq}, 8'h01, "zero interrupt");
		mr(5'h00, v);
		chk(v, 8'h01, "status");
		host_u.wr(5'h00, 8'h01);
		chk({7'h00, irq}, 8'h00, "interrupt cleared");
		mw(5'h01, 8'h0A);
		mw(5'h01, 8'h0B);
		// a new preset must not disturb the held count
		mw(5'h0F, 8'(n0 + 3));
		for (int i = 0; i < 2; i++) begin
			repeat (40) @(negedge clk);
			mw(5'h01, 8'h1B);
			mr(5'h10, v);
			chk(v, 8'h00, "held count high");
			mr(5'h0F, v);
			chk(v, 8'(n0), "held count low");
		end
		mr(5'h0F, v);
		chk(v, regs[15], "preset after latch");
		n0 = n0 + 3;
		mw(5'h01, 8'h03);
		g0 = 1'b1;
		repeat (60) @(negedge clk);
		g0 = 1'b0;
		$display("test rate done");
		mw(5'h01, 8'h04);
		// stale rate interrupt cleared so the next one is the square's
		host_u.wr(5'h00, 8'h01);
		mw(5'h01, 8'h05);
		span(0, 1'b0, n);
		span(0, 1'b1, n);
		repeat (2) @(negedge clk);
		chk({7'h00, irq}, 8'h01, "falling edge interrupt");
		host_u.wr(5'h00, 8'h01);
		span(0, 1'b0, n);
		chk({7'h00, irq}, 8'h00, "no rising interrupt");
		span(0, 1'b1, n);
		chk_cnt(n, (n0 + 1) * DIV, (n0 + 1) * DIV, "square high");
		span(0, 1'b0, n);
		chk_cnt(n, (n0 + 1) * DIV, (n0 + 1) * DIV, "square low");
		mw(5'h01, 8'h04);
		repeat (3) @(negedge clk);
		chk({7'h00, multi_function_output_pin}, 8'h00, "square stopped low");
		$display("test square done");
		// zero single pulse flushes a stale trigger
		mw(5'h11, 8'h00);
		mw(5'h12, 8'h00);
		mw(5'h02, 8'h00);
		mw(5'h02, 8'h01);
		repeat (20) @(negedge clk);
		n1 = 10 + ($unsigned($random(seed)) % 8);
		mw(5'h11, 8'(n1));
		mw(5'h02, 8'h06);
		mw(5'h02, 8'h07);
		host_u.wr(5'h00, 8'h03);
		repeat (30) @(negedge clk);
		chk({7'h00, t1o}, 8'h00, "armed idle");
		g1 = 1'b1;
		repeat (6) @(negedge clk);
		chk({7'h00, t1o}, 8'h01, "trigger");
		chk({7'h00, irq}, 8'h00, "no trigger interrupt");
		g1 = 1'b0;
		repeat (12) @(negedge clk);
		g1 = 1'b1;
		repeat (3) @(negedge clk);
		g1 = 1'b0;
		span(1, 1'b1, n);
		chk_cnt(n + 3, n1 * DIV, n1 * DIV + DIV + 4, "retriggered width");
		repeat (2) @(negedge clk);
		chk({7'h00, irq}, 8'h01, "one-shot interrupt");
		repeat (20) @(negedge clk);
		chk({7'h00, t1o}, 8'h00, "rearmed idle");
		mw(5'h02, 8'h0F);
		chk({7'h00, t1o}, 8'h01, "hold bit trigger");
		$display("test one-shot done");
		complete_run();
	end
endmodule : multimode_timer_tb

`default_nettype wire

// file: tb/timer_host_model.sv
// timer_host_model: byte-wide host driving the timer's register port.
// assumes: strobes pass a two-flop synchroniser, so each is held four clocks.
`default_nettype none

module timer_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] bus_i,
	input  wire logic       oe_i,
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic      [4:0] addr_o,
	output logic      [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cs_n_o  = 1'b1;
		rd_n_o  = 1'b1;
		wr_n_o  = 1'b1;
		addr_o  = 5'h00;
		wdata_o = 8'h00;
	end

	// data is inverted after a write so a late sample cannot match
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o  = a;
		wdata_o = d;
		cs_n_o  = 1'b0;
		wr_n_o  = 1'b0;
		repeat (4) @(negedge clk_i);
		cs_n_o  = 1'b1;
		wr_n_o  = 1'b1;
		wdata_o = ~d;
		repeat (4) @(negedge clk_i);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		@(negedge clk_i);
		addr_o = a;
		cs_n_o = 1'b0;
		rd_n_o = 1'b0;
		// answer is sampled half a clock after it is launched
		@(negedge clk_i);
		while (oe_i !== 1'b1 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		ok = oe_i;
		d  = bus_i;
		@(negedge clk_i);
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		repeat (4) @(negedge clk_i);
	endtask : rd
endmodule : timer_host_model

`default_nettype wire
